//--- src/mtrl_pkg.sv
// Purpose: Shared constants and types for the memory type range lookup block.
// Assumes: 52-bit physical addresses, 64-bit register data.
// Notes:   Register select codes are local choices.
package mtrl_pkg;

    localparam int PA_W       = 52;
    localparam int PAGE_LSB   = 12;
    localparam int PAGE_W     = PA_W - PAGE_LSB;
    localparam int DATA_W     = 64;
    localparam int NUM_VAR    = 8;
    localparam int NUM_FIX    = 11;
    localparam int SEL_W      = 5;

    // Register select codes
    localparam logic [4:0] SEL_FIX64K      = 5'h00;
    localparam logic [4:0] SEL_FIX16K_BASE = 5'h01;
    localparam logic [4:0] SEL_FIX4K_BASE  = 5'h03;
    localparam logic [4:0] SEL_DEFTYPE     = 5'h0B;
    localparam logic [4:0] SEL_VAR_BASE    = 5'h10;

    // Field positions
    localparam int TYPE_LSB   = 0;
    localparam int TYPE_W     = 8;
    localparam int FIX_EN_BIT = 10;
    localparam int EN_BIT     = 11;
    localparam int VALID_BIT  = 11;

    // Address region limits: fixed-range starts in address bits 19:12, one megabyte as a page count
    localparam logic [7:0] FIX16K_START = 8'h80;
    localparam logic [7:0] FIX4K_START  = 8'hC0;
    localparam logic [31:0] ONE_MEG_PAGES = 32'h0000_0100;

    // Reset values
    localparam logic [63:0] REG_RST = 64'h0000_0000_0000_0000;

    // Memory type encodings
    localparam logic [7:0] TYPE_UNCACHED = 8'h00;
    localparam logic [7:0] TYPE_WCOMB    = 8'h01;
    localparam logic [7:0] TYPE_WTHRU    = 8'h04;
    localparam logic [7:0] TYPE_WP       = 8'h05;
    localparam logic [7:0] TYPE_WBACK    = 8'h06;

    // Standard-type field mask: bits 7:3 reserved
    localparam logic [7:0] STD_TYPE_MASK = 8'h07;

endpackage : mtrl_pkg

//--- src/mtrl_var_match.sv
// Purpose: One variable-range pair compare.
// Assumes: Base and mask hold page-number fields.
// Notes:   Combinational.
`timescale 1ns/10ps
`default_nettype none
module mtrl_var_match (
    input  wire logic [mtrl_pkg::PAGE_W-1:0] pageNum,
    input  wire logic [mtrl_pkg::PAGE_W-1:0] rangeBase,
    input  wire logic [mtrl_pkg::PAGE_W-1:0] rangeMask,
    input  wire logic                        rangeValid,
    output logic                             hit
);
    import mtrl_pkg::*;

    // Masked base against masked page number
    assign hit = rangeValid && ((rangeMask & rangeBase) == (rangeMask & pageNum));

endmodule : mtrl_var_match
`default_nettype wire

//--- src/mtrl_lookup.sv
// Purpose: Memory type range registers and address-to-type lookup.
// Assumes: Register port is driven by the read/write model-register instructions.
// Notes:   Lookup is combinational; registers are synchronous.
`timescale 1ns/10ps
`default_nettype none
module mtrl_lookup (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    // Register access port
    input  wire logic                          regWrite,
    input  wire logic [mtrl_pkg::SEL_W-1:0]    regSel,
    input  wire logic [mtrl_pkg::DATA_W-1:0]   regWdata,
    output logic      [mtrl_pkg::DATA_W-1:0]   regRdata,
    output logic                               regValid,
    // Lookup port
    input  wire logic [mtrl_pkg::PA_W-1:0]     lookupAddr,
    output logic      [mtrl_pkg::TYPE_W-1:0]   lookupType,
    output logic                               allowCache,
    output logic                               allowWriteCombine,
    output logic                               allowSpeculate,
    output logic                               allocOnReadMiss,
    output logic                               allocOnWriteMiss,
    output logic                               writeToMemory,
    output logic                               invalidateOnWriteHit
);
    import mtrl_pkg::*;

    typedef struct packed {
        logic [NUM_FIX-1:0][DATA_W-1:0] fixReg;
        logic [NUM_VAR-1:0][DATA_W-1:0] baseReg;
        logic [NUM_VAR-1:0][DATA_W-1:0] maskReg;
        logic [DATA_W-1:0]              defReg;
        logic [DATA_W-1:0]              rdata;
        logic                           rvalid;
    } mtrl_state_s;

    typedef enum {SEL_KIND_FIX, SEL_KIND_DEF, SEL_KIND_VAR, SEL_KIND_NONE} mtrl_sel_e;

    mtrl_state_s state_r;
    mtrl_state_s state_nxt;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [TYPE_W-1:0] fix_field(input logic [DATA_W-1:0] r, input logic [2:0] idx);
        return TYPE_W'(r >> {idx, 3'h0});
    endfunction : fix_field

    // Register select decode, shared by the read and write paths
    function automatic mtrl_sel_e sel_kind(input logic [SEL_W-1:0] s);
        if (s < SEL_DEFTYPE) begin
            return SEL_KIND_FIX;
        end else if (s == SEL_DEFTYPE) begin
            return SEL_KIND_DEF;
        end else if (s >= SEL_VAR_BASE) begin
            return SEL_KIND_VAR;
        end
        return SEL_KIND_NONE;
    endfunction : sel_kind

    // Fixed ranges only ever cover page numbers below one megabyte
    function automatic logic below_one_meg(input logic [PAGE_W-1:0] page);
        return page < PAGE_W'(ONE_MEG_PAGES);
    endfunction : below_one_meg

    // Stored base register image: type forced to standard bits
    function automatic logic [DATA_W-1:0] base_image(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = '0;
        v[PA_W-1:PAGE_LSB] = d[PA_W-1:PAGE_LSB];
        v[TYPE_W-1:0]      = d[TYPE_W-1:0] & STD_TYPE_MASK;
        return v;
    endfunction : base_image

    function automatic logic [DATA_W-1:0] mask_image(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = '0;
        v[PA_W-1:PAGE_LSB] = d[PA_W-1:PAGE_LSB];
        v[VALID_BIT]       = d[VALID_BIT];
        return v;
    endfunction : mask_image

    function automatic logic [DATA_W-1:0] def_image(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        v = '0;
        v[TYPE_W-1:0] = d[TYPE_W-1:0] & STD_TYPE_MASK;
        v[FIX_EN_BIT] = d[FIX_EN_BIT];
        v[EN_BIT]     = d[EN_BIT];
        return v;
    endfunction : def_image

    // ****************************************************************
    // Register state
    // ****************************************************************
    always_comb begin
        logic [4:0] vIdx;
        vIdx = regSel - SEL_VAR_BASE;
        state_nxt        = state_r;
        state_nxt.rvalid = 1'b1;
        state_nxt.rdata  = '0;
        // Read path, 64-bit whole register
        unique case (sel_kind(regSel))
            SEL_KIND_FIX: begin
                state_nxt.rdata = state_r.fixReg[regSel[3:0]];
            end
            SEL_KIND_DEF: begin
                state_nxt.rdata = state_r.defReg;
            end
            SEL_KIND_VAR: begin
                state_nxt.rdata = vIdx[0] ? state_r.maskReg[vIdx[3:1]] : state_r.baseReg[vIdx[3:1]];
            end
            SEL_KIND_NONE: begin
                state_nxt.rvalid = 1'b0;
            end
        endcase
        if (regWrite) begin
            unique case (sel_kind(regSel))
                SEL_KIND_FIX: begin
                    state_nxt.fixReg[regSel[3:0]] = regWdata;
                end
                SEL_KIND_DEF: begin
                    state_nxt.defReg = def_image(regWdata);
                end
                SEL_KIND_VAR: begin
                    if (vIdx[0]) begin
                        state_nxt.maskReg[vIdx[3:1]] = mask_image(regWdata);
                    end else begin
                        state_nxt.baseReg[vIdx[3:1]] = base_image(regWdata);
                    end
                end
                SEL_KIND_NONE: begin
                    state_nxt.rvalid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign regRdata = state_r.rdata;
    assign regValid = state_r.rvalid;

    // ****************************************************************
    // Variable range compare
    // ****************************************************************
    logic [NUM_VAR-1:0] varHit;

    for (genvar g = 0; g < NUM_VAR; g++) begin : gVar
        mtrl_var_match uMatch (
            .pageNum    (lookupAddr[PA_W-1:PAGE_LSB]),
            .rangeBase  (state_r.baseReg[g][PA_W-1:PAGE_LSB]),
            .rangeMask  (state_r.maskReg[g][PA_W-1:PAGE_LSB]),
            .rangeValid (state_r.maskReg[g][VALID_BIT]),
            .hit        (varHit[g])
        );
    end

    // ****************************************************************
    // Type resolution
    // ****************************************************************
    logic       inFirstMeg;
    logic [7:0] pg;
    logic [3:0] fixIdx;
    logic [2:0] fieldIdx;
    logic [7:0] fixType;
    logic [7:0] varType;
    logic       anyVar;
    logic       anyUncached;
    logic       anyThru;
    logic       allSame;
    logic       onlyThruBack;

    assign pg         = lookupAddr[19:12];
    assign inFirstMeg = below_one_meg(lookupAddr[PA_W-1:PAGE_LSB]);

    always_comb begin
        fixIdx   = '0;
        fieldIdx = '0;
        if (pg < FIX16K_START) begin
            fixIdx   = 4'h0;
            fieldIdx = pg[6:4];
        end else if (pg < FIX4K_START) begin
            fixIdx   = 4'h1 + {3'h0, pg[5]};
            fieldIdx = pg[4:2];
        end else begin
            fixIdx   = 4'h3 + {1'b0, pg[5:3]};
            fieldIdx = pg[2:0];
        end
        fixType = fix_field(state_r.fixReg[fixIdx], fieldIdx);
    end

    always_comb begin
        logic [7:0] t;
        t            = '0;
        anyVar       = 1'b0;
        anyUncached  = 1'b0;
        anyThru      = 1'b0;
        allSame      = 1'b1;
        onlyThruBack = 1'b1;
        varType      = TYPE_UNCACHED;
        for (int i = 0; i < NUM_VAR; i++) begin
            if (varHit[i]) begin
                t = state_r.baseReg[i][7:0];
                if (anyVar && t != varType) begin
                    allSame = 1'b0;
                end
                if (!anyVar) begin
                    varType = t;
                end
                anyVar      = 1'b1;
                anyUncached = anyUncached | (t == TYPE_UNCACHED);
                anyThru     = anyThru | (t == TYPE_WTHRU);
                if (t != TYPE_WTHRU && t != TYPE_WBACK) begin
                    onlyThruBack = 1'b0;
                end
            end
        end
        // Overlap resolution; other mixes are undefined, uncacheable is the safe answer
        if (anyUncached || !allSame) begin
            varType = (anyUncached || !(onlyThruBack && anyThru)) ? TYPE_UNCACHED : TYPE_WTHRU;
        end
    end

    always_comb begin
        if (!state_r.defReg[EN_BIT]) begin
            lookupType = TYPE_UNCACHED;
        end else if (state_r.defReg[FIX_EN_BIT] && inFirstMeg) begin
            lookupType = fixType;
        end else if (anyVar) begin
            lookupType = varType;
        end else begin
            lookupType = state_r.defReg[7:0];
        end
    end

    // ****************************************************************
    // Access behaviour per type
    // ****************************************************************
    always_comb begin
        allowCache           = 1'b0;
        allowWriteCombine    = 1'b0;
        allowSpeculate       = 1'b0;
        allocOnReadMiss      = 1'b0;
        allocOnWriteMiss     = 1'b0;
        writeToMemory        = 1'b1;
        invalidateOnWriteHit = 1'b0;
        unique case (lookupType[2:0])
            TYPE_WCOMB[2:0]: begin
                allowWriteCombine = 1'b1;
                allowSpeculate    = 1'b1;
            end
            TYPE_WTHRU[2:0]: begin
                allowCache      = 1'b1;
                allocOnReadMiss = 1'b1;
            end
            TYPE_WP[2:0]: begin
                allowCache           = 1'b1;
                allocOnReadMiss      = 1'b1;
                invalidateOnWriteHit = 1'b1;
            end
            TYPE_WBACK[2:0]: begin
                allowCache       = 1'b1;
                allocOnReadMiss  = 1'b1;
                allocOnWriteMiss = 1'b1;
                writeToMemory    = 1'b0;
            end
            default: begin
                allowCache = 1'b0;
            end
        endcase
    end

endmodule : mtrl_lookup
`default_nettype wire

//--- dv/mtrl_lookup_properties.sv
// Purpose: Port assertions for the memory type lookup block.
// Assumes: Global enable is tracked from default-type register writes.
// Notes:   Bound to every lookup instance.
`timescale 1ns/10ps
`default_nettype none
module mtrl_lookup_properties (
    input wire logic                        mclk,
    input wire logic                        nrst,
    input wire logic                        regWrite,
    input wire logic [mtrl_pkg::SEL_W-1:0]  regSel,
    input wire logic [mtrl_pkg::DATA_W-1:0] regWdata,
    input wire logic [mtrl_pkg::DATA_W-1:0] regRdata,
    input wire logic                        regValid,
    input wire logic [mtrl_pkg::TYPE_W-1:0] lookupType,
    input wire logic                        allowCache,
    input wire logic                        allowWriteCombine,
    input wire logic                        allowSpeculate,
    input wire logic                        allocOnReadMiss,
    input wire logic                        allocOnWriteMiss,
    input wire logic                        writeToMemory,
    input wire logic                        invalidateOnWriteHit
);
    import mtrl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic enShadow_r;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            enShadow_r <= 1'b0;
        end else if (regWrite && regSel == SEL_DEFTYPE) begin
            enShadow_r <= regWdata[EN_BIT];
        end
    end
    property p_uc; lookupType[2:0] == 3'h0 |-> writeToMemory && !allowCache && !allowWriteCombine && !allowSpeculate; endproperty
    a_uc: assert property (p_uc) else $error("uncacheable flags wrong");
    property p_wc; lookupType[2:0] == 3'h1 |-> allowWriteCombine && allowSpeculate && !allowCache; endproperty
    a_wc: assert property (p_wc) else $error("write-combining flags wrong");
    property p_wt; lookupType[2:0] == 3'h4 |-> allowCache && allocOnReadMiss && !allocOnWriteMiss && writeToMemory; endproperty
    a_wt: assert property (p_wt) else $error("writethrough flags wrong");
    property p_wp; lookupType[2:0] == 3'h5 |-> allocOnReadMiss && !allocOnWriteMiss && invalidateOnWriteHit; endproperty
    a_wp: assert property (p_wp) else $error("write-protect flags wrong");
    property p_wb; lookupType[2:0] == 3'h6 |-> allocOnReadMiss && allocOnWriteMiss && !writeToMemory; endproperty
    a_wb: assert property (p_wb) else $error("writeback flags wrong");
    property p_off; !enShadow_r |-> lookupType == TYPE_UNCACHED; endproperty
    a_off: assert property (p_off) else $error("typing disabled but type not uncacheable");
    property p_rb; (regWrite && regSel == SEL_FIX64K) ##1 regSel == SEL_FIX64K |=> regRdata == $past(regWdata, 2); endproperty
    a_rb: assert property (p_rb) else $error("fixed register readback wrong");
    property p_unm; regSel inside {[5'h0C:5'h0F]} |=> !regValid && regRdata == 64'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped select answered");
    property p_map; !(regSel inside {[5'h0C:5'h0F]}) |=> regValid; endproperty
    a_map: assert property (p_map) else $error("mapped select not valid");
endmodule : mtrl_lookup_properties
bind mtrl_lookup mtrl_lookup_properties mtrl_lookup_properties_inst (.mclk, .nrst, .regWrite, .regSel, .regWdata,
    .regRdata, .regValid, .lookupType, .allowCache, .allowWriteCombine, .allowSpeculate, .allocOnReadMiss,
    .allocOnWriteMiss, .writeToMemory, .invalidateOnWriteHit);
`default_nettype wire

//--- dv/mtrl_host_model.sv
// Purpose: Software and pipeline side driving registers and lookups.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Write data is scrambled once the strobe drops.
`timescale 1ns/10ps
`default_nettype none
module mtrl_host_model (
    input  wire logic                        mclk,
    input  wire logic [mtrl_pkg::DATA_W-1:0] regRdata,
    input  wire logic                        regValid,
    output logic                             regWrite,
    output logic      [mtrl_pkg::SEL_W-1:0]  regSel,
    output logic      [mtrl_pkg::DATA_W-1:0] regWdata,
    output logic      [mtrl_pkg::PA_W-1:0]   lookupAddr
);
    import mtrl_pkg::*;
    initial begin
        regWrite = 1'b0;
        regSel = 5'h00;
        regWdata = 64'h0;
        lookupAddr = 52'h0;
    end
    // Mask of a power-of-two range aligned on its own size
    function automatic logic [63:0] vmask(input logic [63:0] size, input logic on);
        return ((64'h0010_0000_0000_0000 - size) & 64'h000F_FFFF_FFFF_F000) | {52'h0, on, 11'h0};
    endfunction : vmask
    task automatic wr(input logic [4:0] sel, input logic [63:0] d);
        @(negedge mclk);
        regWrite = 1'b1;
        regSel = sel;
        regWdata = d;
        @(negedge mclk);
        regWrite = 1'b0;
        regWdata = ~d;
    endtask : wr
    task automatic rd(input logic [4:0] sel, output logic [63:0] d, output logic v);
        @(negedge mclk);
        regSel = sel;
        @(negedge mclk);
        d = regRdata;
        v = regValid;
    endtask : rd
    task automatic lk(input logic [51:0] a);
        @(negedge mclk);
        lookupAddr = a;
        #1;
    endtask : lk
endmodule : mtrl_host_model
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the memory type lookup block.
// Assumes: Host model drives registers and lookup addresses.
// Notes:   Table rows cover the map; special cases follow the loop.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mtrl_pkg::*;
    logic              mclk;
    logic              nrst;
    logic              regWrite;
    logic [SEL_W-1:0]  regSel;
    logic [DATA_W-1:0] regWdata;
    logic [DATA_W-1:0] regRdata;
    logic              regValid;
    logic [PA_W-1:0]   lookupAddr;
    logic [TYPE_W-1:0] lookupType;
    logic [63:0]       rdData;
    logic              rdValid;
    int                failures;
    int                checkCount;
    localparam logic [51:0] ROW_ADDR [14] = '{52'h0, 52'h2_0000, 52'h4_0000, 52'h8_4000, 52'hB_C000, 52'hC_0000,
        52'hF_F000, 52'h10_0000, 52'h200_0000, 52'h200_1000, 52'h300_0000, 52'h400_0000, 52'hF_FFFF_F123_4567,
        52'hF_FFFF_E000_0000};
    localparam logic [7:0] ROW_TYPE [14] = '{8'h04, 8'h06, 8'h01, 8'h1E, 8'h05, 8'h06, 8'h01, 8'h05, 8'h04, 8'h06,
        8'h00, 8'h05, 8'h01, 8'h05};
    localparam logic [63:0] VAR_BASE [7] = '{64'h200_0006, 64'h200_0004, 64'h0, 64'h300_0000, 64'h400_0001,
        64'hF_FFFF_F000_0001, 64'hF_FFFF_F000_0001};
    localparam logic [63:0] VAR_SIZE [7] = '{64'h200_0000, 64'h1000, 64'h10_0000, 64'h1000, 64'h100_0000,
        64'h1000_0000, 64'h1000_0000};
    localparam logic [6:0] VAR_ON = 7'h6F;
    localparam logic [4:0] RB_SEL [3] = '{5'h1E, 5'h1F, 5'h0C};
    localparam logic [63:0] RB_EXP [3] = '{64'h000F_FFFF_FFFF_F007, 64'h000F_FFFF_FFFF_F800, 64'h0};
    mtrl_lookup mtrl_lookup_inst (.mclk, .nrst, .regWrite, .regSel, .regWdata, .regRdata, .regValid, .lookupAddr,
        .lookupType, .allowCache(), .allowWriteCombine(), .allowSpeculate(), .allocOnReadMiss(),
        .allocOnWriteMiss(), .writeToMemory(), .invalidateOnWriteHit());
    mtrl_host_model mtrl_host_model_inst (.mclk, .regRdata, .regValid, .regWrite, .regSel, .regWdata, .lookupAddr);
    task automatic chk_data(input string name, input logic [63:0] exp, input logic [63:0] got);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_data
    task automatic look(input logic [51:0] addr, input logic [7:0] exp);
        mtrl_host_model_inst.lk(addr);
        chk_data("lookup type", {56'h0, exp}, {56'h0, lookupType});
    endtask : look
    task automatic give_verdict;
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #1_000_000;
        failures++;
        give_verdict();
    end
    initial begin
        nrst = 1'b0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        mtrl_host_model_inst.rd(SEL_DEFTYPE, rdData, rdValid);
        chk_data("reset default type", 64'h0, rdData);
        look(52'hC_0000, TYPE_UNCACHED);
        mtrl_host_model_inst.wr(SEL_FIX64K, 64'h0605_0401_0006_0504);
        mtrl_host_model_inst.wr(SEL_FIX16K_BASE, 64'h1E00);
        mtrl_host_model_inst.wr(5'h02, 64'h0500_0000_0000_0000);
        mtrl_host_model_inst.wr(SEL_FIX4K_BASE, 64'h06);
        mtrl_host_model_inst.wr(5'h0A, 64'h0100_0000_0000_0000);
        for (int i = 0; i < 7; i++) begin
            mtrl_host_model_inst.wr(SEL_VAR_BASE + 5'(2 * i), VAR_BASE[i]);
            mtrl_host_model_inst.wr(SEL_VAR_BASE + 5'(2 * i + 1),
                                    mtrl_host_model_inst.vmask(VAR_SIZE[i], VAR_ON[i]));
        end
        mtrl_host_model_inst.wr(SEL_DEFTYPE, 64'hC05);
        for (int i = 0; i < 14; i++) begin
            look(ROW_ADDR[i], ROW_TYPE[i]);
        end
        mtrl_host_model_inst.wr(SEL_DEFTYPE, 64'h805);
        look(52'hC_0000, TYPE_UNCACHED);
        look(52'h200_1000, TYPE_WBACK);
        mtrl_host_model_inst.wr(SEL_DEFTYPE, 64'h006);
        look(52'h200_1000, TYPE_UNCACHED);
        look(52'h10_0000, TYPE_UNCACHED);
        mtrl_host_model_inst.rd(SEL_FIX64K, rdData, rdValid);
        chk_data("fixed 64K readback", 64'h0605_0401_0006_0504, rdData);
        for (int i = 0; i < 3; i++) begin
            mtrl_host_model_inst.wr(RB_SEL[i], 64'hFFFF_FFFF_FFFF_FFFF);
            mtrl_host_model_inst.rd(RB_SEL[i], rdData, rdValid);
            chk_data("masked readback", RB_EXP[i], rdData);
            chk_data("readback valid", {63'h0, i < 2}, {63'h0, rdValid});
        end
        // Mid-run reset clears every register
        @(negedge mclk);
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        mtrl_host_model_inst.rd(SEL_FIX64K, rdData, rdValid);
        chk_data("fixed 64K after reset", 64'h0, rdData);
        chk_data("valid after reset", 64'h1, {63'h0, rdValid});
        look(52'h0, TYPE_UNCACHED);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
